// >>> hdl/tps_pkg.sv
// Purpose: shared constants and types of the transmit pulse shaper
// Assumes: AXI4-Lite slave with 32-bit data, byte addresses below 0x40
// Notes: register offsets are used by the top level and the bench, bit positions by the top level only
// Behaviour
// - Template select 0000 plays the 75 ohm preset, 0001 the other preset.
// - Scale 100001 is unity; each step away changes amplitude by 3 percent.
// - Template select pattern 1XXX plays the user programmed waveform.
// - A user waveform is 20 sub-phase samples indexed by a 5-bit field.
// - Samples are 7-bit sign-magnitude, from -63 to +63.
// - Eight reference sample sets are held in a read-only table.
// - Sample write: load sample register, then control with rw 0, done 1.
// - Sample read: control with rw 1, done 1; data appears in sample register.
// - Overlapping pulses beyond the limit set a sticky overflow flag, which raises irq unless masked.
// - Global enable pin low or drive enable bit low tristates the drivers.
// - Over-current limits drive current, or tristates if that bit is set.
// - Over-current state is shown; edges set the event per edge select.
// - The over-current event raises the interrupt unless masked.
// - Single-ended mode drives only the positive output.
package tps_pkg;
	localparam int ADDR_W = 6;
	localparam logic [5:0] ADDR_TX_CFG = 6'h00;
	localparam logic [5:0] ADDR_PULSE = 6'h04;
	localparam logic [5:0] ADDR_SCALE = 6'h08;
	localparam logic [5:0] ADDR_ACC_CTRL = 6'h0C;
	localparam logic [5:0] ADDR_SAMPLE = 6'h10;
	localparam logic [5:0] ADDR_STATUS = 6'h14;
	localparam logic [5:0] ADDR_IRQ_STAT = 6'h18;
	localparam logic [5:0] ADDR_IRQ_MASK = 6'h1C;
	localparam logic [5:0] ADDR_EDGE_SEL = 6'h20;

	localparam int CFG_DRV_EN_BIT = 6;
	localparam int CFG_TRI_OC_BIT = 4;
	localparam int CFG_SINGLE_BIT = 3;
	localparam logic [6:0] CFG_WMASK = 7'h5F;
	localparam logic [6:0] CFG_RST = 7'h00;

	localparam int PULSE_W = 4;
	localparam int PULSE_EXT_BIT = 3;
	localparam logic [3:0] PULSE_RST = 4'h1;

	localparam int SCALE_W = 6;
	localparam logic [5:0] SCALE_UNITY = 6'h21;
	localparam int SCALE_STEP_PCT = 3;
	localparam int PCT_BASE = 100;

	localparam int IDX_W = 5;
	localparam int ACC_RW_BIT = 5;
	localparam int ACC_DONE_BIT = 6;
	localparam int SAMPLE_W = 7;
	localparam int SAMPLE_SIGN_BIT = 6;
	localparam int SAMPLE_MAX = 63;
	localparam int NUM_SAMPLES = 20;
	localparam logic [4:0] LAST_PHASE = 5'h13;
	localparam int NUM_REF_SETS = 8;

	localparam int OC_BIT = 4;
	localparam int OVF_BIT = 7;
	localparam logic [7:0] IRQ_BITS = 8'h90;
	localparam logic [7:0] MASK_RST = 8'h90;

	localparam int LEVEL_W = 8;
	localparam int LEVEL_MAX = 127;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [4:0] REF_IDX_RISE = 5'h03;
	localparam logic [4:0] REF_IDX_PEAK = 5'h04;
	// odd sets carry the 120 ohm shape, even sets the 75 ohm shape
	localparam logic [6:0] REF_RISE [NUM_REF_SETS] = '{
		7'h0C, 7'h0F, 7'h0C, 7'h0F, 7'h0C, 7'h0F, 7'h0C, 7'h0F};
	localparam logic [6:0] REF_PEAK [NUM_REF_SETS] = '{
		7'h30, 7'h3C, 7'h30, 7'h3C, 7'h30, 7'h3C, 7'h30, 7'h3C};

	typedef enum logic [1:0] {
		ACC_IDLE = 2'h0,
		ACC_RUN = 2'h1,
		ACC_FIN = 2'h3,
		ACC_SPARE = 2'h2
	} tps_acc_t;
endpackage

// >>> hdl/tps_wave_ram.sv
// Purpose: user waveform sample store with registered read ports
// Assumes: one write port, reads see the value stored before the edge
// Notes: out-of-range addresses read zero and ignore writes
`timescale 1ns/1ns
module tps_wave_ram #(
	parameter int DATA_W = 7,
	parameter int DEPTH = 20,
	parameter int ADDR_W = 5,
	parameter int NUM_RD = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic [NUM_RD*ADDR_W-1:0] rd_addr,
	output logic [NUM_RD*DATA_W-1:0] rd_data
);
	logic [DATA_W-1:0] mem_reg [DEPTH];
	logic [DATA_W-1:0] mem_next [DEPTH];
	logic [NUM_RD*DATA_W-1:0] rd_next;

	always_comb begin
		mem_next = mem_reg;
		if (wr_en && (int'(wr_addr) < DEPTH)) begin
			mem_next[wr_addr] = wr_data;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_RD; g++) begin : g_rd
			logic [ADDR_W-1:0] a;
			assign a = rd_addr[g*ADDR_W +: ADDR_W];
			assign rd_next[g*DATA_W +: DATA_W] =
				(int'(a) < DEPTH) ? mem_reg[a] : '0;
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
			rd_data <= '0;
		end else begin
			mem_reg <= mem_next;
			rd_data <= rd_next;
		end
	end
endmodule

// >>> hdl/tps_ref_rom.sv
// Purpose: read-only reference sample sets for the preset templates
// Assumes: one set chosen for all ports at a time
// Notes: samples outside the two shaped sub-phases are zero
`timescale 1ns/1ns
module tps_ref_rom #(
	parameter int NUM_RD = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] set_sel,
	input wire logic [NUM_RD*tps_pkg::IDX_W-1:0] rd_addr,
	output logic [NUM_RD*tps_pkg::SAMPLE_W-1:0] rd_data
);
	localparam int AW = tps_pkg::IDX_W;
	localparam int DW = tps_pkg::SAMPLE_W;
	logic [NUM_RD*DW-1:0] rd_next;

	function automatic logic [DW-1:0] ref_sample(logic [2:0] set,
		logic [AW-1:0] idx);
		logic [DW-1:0] v;
		v = '0;
		if (idx == tps_pkg::REF_IDX_RISE) begin
			v = tps_pkg::REF_RISE[set];
		end else if (idx == tps_pkg::REF_IDX_PEAK) begin
			v = tps_pkg::REF_PEAK[set];
		end
		return v;
	endfunction

	genvar g;
	generate
		for (g = 0; g < NUM_RD; g++) begin : g_rd
			assign rd_next[g*DW +: DW] =
				ref_sample(set_sel, rd_addr[g*AW +: AW]);
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_data <= '0;
		end else begin
			rd_data <= rd_next;
		end
	end
endmodule

// >>> hdl/tps_top.sv
// Purpose: one-channel transmit pulse shaper and line driver control
// Assumes: inputs synchronous to aclk; bit_start coincides with a strobe
// Notes: sample_strobe steps one sub-phase, 16 steps per unit interval
`timescale 1ns/1ns
module tps_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tps_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tps_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic global_oe,
	input wire logic tx_overcurrent,
	input wire logic sample_strobe,
	input wire logic bit_start,
	input wire logic mark,
	input wire logic mark_neg,
	output logic [tps_pkg::LEVEL_W-1:0] line_out_pos,
	output logic line_out_pos_oe,
	output logic [tps_pkg::LEVEL_W-1:0] line_out_neg,
	output logic line_out_neg_oe,
	output logic current_limit,
	output logic irq_out_n
);
	localparam int AW = tps_pkg::IDX_W;
	localparam int DW = tps_pkg::SAMPLE_W;
	localparam int LW = tps_pkg::LEVEL_W;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ---- bus handshake
	logic wr_fire, rd_fire;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;

	// ---- software state
	logic [6:0] cfg_reg, cfg_next;
	logic [3:0] pulse_reg, pulse_next;
	logic [5:0] scale_reg, scale_next;
	logic [7:0] mask_reg, mask_next;
	logic edge_reg, edge_next;
	logic [AW-1:0] acc_idx_reg, acc_idx_next;
	logic acc_rw_reg, acc_rw_next;
	logic [DW-1:0] sample_reg, sample_next;
	tps_pkg::tps_acc_t acc_state_reg, acc_state_next;
	logic acc_start, acc_done, ram_we;

	// ---- playback, status
	logic [AW-1:0] cur_ph_reg, cur_ph_next, prev_ph_reg, prev_ph_next;
	logic cur_act_reg, cur_act_next, prev_act_reg, prev_act_next;
	logic cur_neg_reg, cur_neg_next, prev_neg_reg, prev_neg_next;
	logic cur_act_d_reg, prev_act_d_reg, cur_neg_d_reg, prev_neg_d_reg;
	logic strobe_d_reg;
	logic [LW-1:0] pos_reg, pos_next, neg_reg, neg_next;
	logic oc_state_reg, oc_evt, ovf_evt;
	logic [7:0] irq_stat_reg, irq_stat_next;
	logic [3*DW-1:0] ram_rd;
	logic [2*DW-1:0] rom_rd;
	logic [DW-1:0] src_cur, src_prev;
	logic signed [LW-1:0] cur_v, prev_v, sum_v;
	logic [5:0] sum_mag;
	logic [LW-2:0] scaled_mag;
	logic user_wave, drive_on;

	function automatic logic is_mapped(logic [tps_pkg::ADDR_W-1:0] a);
		return a == tps_pkg::ADDR_TX_CFG || a == tps_pkg::ADDR_PULSE ||
			a == tps_pkg::ADDR_SCALE || a == tps_pkg::ADDR_ACC_CTRL ||
			a == tps_pkg::ADDR_SAMPLE || a == tps_pkg::ADDR_STATUS ||
			a == tps_pkg::ADDR_IRQ_STAT || a == tps_pkg::ADDR_IRQ_MASK ||
			a == tps_pkg::ADDR_EDGE_SEL;
	endfunction

	function automatic logic signed [LW-1:0] sm_value(logic [DW-1:0] s,
		logic act, logic neg);
		logic signed [LW-1:0] m;
		m = $signed({2'h0, s[5:0]});
		if (!act) begin
			return '0;
		end
		return (s[tps_pkg::SAMPLE_SIGN_BIT] ^ neg) ? -m : m;
	endfunction

	// address and data are taken together, one write in flight
	assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign rd_fire = s_axi_arvalid && !rvalid_reg;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	assign s_axi_arready = !rvalid_reg;

	always_comb begin
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (wr_fire) begin
			bvalid_next = 1'b1;
			bresp_next = is_mapped(s_axi_awaddr) ? tps_pkg::RESP_OKAY :
				tps_pkg::RESP_SLVERR;
		end
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (rd_fire) begin
			rvalid_next = 1'b1;
			rresp_next = is_mapped(s_axi_araddr) ? tps_pkg::RESP_OKAY :
				tps_pkg::RESP_SLVERR;
			rdata_next = '0;
			case (s_axi_araddr)
				tps_pkg::ADDR_TX_CFG: rdata_next[6:0] = cfg_reg;
				tps_pkg::ADDR_PULSE: rdata_next[3:0] = pulse_reg;
				tps_pkg::ADDR_SCALE: rdata_next[5:0] = scale_reg;
				tps_pkg::ADDR_ACC_CTRL: begin
					rdata_next[AW-1:0] = acc_idx_reg;
					rdata_next[tps_pkg::ACC_RW_BIT] = acc_rw_reg;
					rdata_next[tps_pkg::ACC_DONE_BIT] = acc_done;
				end
				tps_pkg::ADDR_SAMPLE: rdata_next[DW-1:0] = sample_reg;
				tps_pkg::ADDR_STATUS: rdata_next[tps_pkg::OC_BIT] = oc_state_reg;
				tps_pkg::ADDR_IRQ_STAT: rdata_next[7:0] = irq_stat_reg;
				tps_pkg::ADDR_IRQ_MASK: rdata_next[7:0] = mask_reg;
				tps_pkg::ADDR_EDGE_SEL: rdata_next[tps_pkg::OC_BIT] = edge_reg;
				default: rdata_next = '0;
			endcase
		end
	end

	// ---- register writes
	always_comb begin
		cfg_next = cfg_reg;
		pulse_next = pulse_reg;
		scale_next = scale_reg;
		mask_next = mask_reg;
		edge_next = edge_reg;
		acc_idx_next = acc_idx_reg;
		acc_rw_next = acc_rw_reg;
		sample_next = sample_reg;
		acc_start = 1'b0;
		if (wr_fire && s_axi_wstrb[0]) begin
			case (s_axi_awaddr)
				tps_pkg::ADDR_TX_CFG: cfg_next = s_axi_wdata[6:0] & tps_pkg::CFG_WMASK;
				tps_pkg::ADDR_PULSE: pulse_next = s_axi_wdata[3:0];
				tps_pkg::ADDR_SCALE: scale_next = s_axi_wdata[5:0];
				tps_pkg::ADDR_ACC_CTRL: begin
					// a new access is ignored until the running one is done
					if (acc_state_reg == tps_pkg::ACC_IDLE &&
						s_axi_wdata[tps_pkg::ACC_DONE_BIT]) begin
						acc_start = 1'b1;
						acc_idx_next = s_axi_wdata[AW-1:0];
						acc_rw_next = s_axi_wdata[tps_pkg::ACC_RW_BIT];
					end
				end
				tps_pkg::ADDR_SAMPLE: begin
					if (acc_state_reg == tps_pkg::ACC_IDLE) begin
						sample_next = s_axi_wdata[DW-1:0];
					end
				end
				tps_pkg::ADDR_IRQ_MASK: mask_next = s_axi_wdata[7:0] & tps_pkg::IRQ_BITS;
				tps_pkg::ADDR_EDGE_SEL: edge_next = s_axi_wdata[tps_pkg::OC_BIT];
				default: ;
			endcase
		end
		if (acc_state_reg == tps_pkg::ACC_FIN && acc_rw_reg) begin
			sample_next = ram_rd[2*DW +: DW];
		end
	end

	// ---- indirect sample access
	always_comb begin
		case (acc_state_reg)
			tps_pkg::ACC_IDLE: acc_state_next = acc_start ? tps_pkg::ACC_RUN :
				tps_pkg::ACC_IDLE;
			tps_pkg::ACC_RUN: acc_state_next = tps_pkg::ACC_FIN;
			tps_pkg::ACC_FIN: acc_state_next = tps_pkg::ACC_IDLE;
			default: acc_state_next = tps_pkg::ACC_IDLE;
		endcase
	end
	assign acc_done = acc_state_reg != tps_pkg::ACC_IDLE;
	assign ram_we = acc_state_reg == tps_pkg::ACC_RUN && !acc_rw_reg;

	sequence s_start_write;
		acc_start && !acc_rw_next;
	endsequence
	sequence s_access_walk;
		acc_state_reg == tps_pkg::ACC_RUN ##1
		acc_state_reg == tps_pkg::ACC_FIN ##1 !acc_done;
	endsequence
	a_write_walk: assert property (s_start_write |=> ram_we ##0 s_access_walk)
		else $error("sample write did not store and finish");
	a_read_data: assert property (acc_state_reg == tps_pkg::ACC_FIN &&
		acc_rw_reg |=> sample_reg == $past(ram_rd[2*DW +: DW]))
		else $error("read sample not presented");

	// ---- pulse phase tracking; a pulse spans 20 sub-phases
	always_comb begin
		cur_ph_next = cur_ph_reg;
		cur_act_next = cur_act_reg;
		cur_neg_next = cur_neg_reg;
		prev_ph_next = prev_ph_reg;
		prev_act_next = prev_act_reg;
		prev_neg_next = prev_neg_reg;
		if (sample_strobe) begin
			cur_ph_next = cur_ph_reg + 5'h01;
			prev_ph_next = prev_ph_reg + 5'h01;
			if (cur_ph_reg == tps_pkg::LAST_PHASE) begin
				cur_act_next = 1'b0;
				cur_ph_next = '0;
			end
			if (prev_ph_reg == tps_pkg::LAST_PHASE) begin
				prev_act_next = 1'b0;
				prev_ph_next = '0;
			end
			if (bit_start) begin
				// the tail of the old pulse overlaps the new one
				prev_ph_next = cur_ph_next;
				prev_act_next = cur_act_next;
				prev_neg_next = cur_neg_reg;
				cur_ph_next = '0;
				cur_act_next = mark;
				cur_neg_next = mark_neg;
			end
		end
	end
	a_phase_bound: assert property (cur_ph_reg < 5'(tps_pkg::NUM_SAMPLES) &&
		prev_ph_reg < 5'(tps_pkg::NUM_SAMPLES))
		else $error("sub-phase index out of range");

	// ---- sample source, overlap sum, scaling
	assign user_wave = pulse_reg[tps_pkg::PULSE_EXT_BIT];
	// low select bits pick the ROM set; 0 and 1 are the two presets
	assign src_cur = user_wave ? ram_rd[0 +: DW] : rom_rd[0 +: DW];
	assign src_prev = user_wave ? ram_rd[DW +: DW] : rom_rd[DW +: DW];
	assign cur_v = sm_value(src_cur, cur_act_d_reg, cur_neg_d_reg);
	assign prev_v = sm_value(src_prev, prev_act_d_reg, prev_neg_d_reg);
	assign sum_v = cur_v + prev_v;

	always_comb begin
		int mag;
		int coef;
		int prod;
		mag = (sum_v < 0) ? -int'(sum_v) : int'(sum_v);
		ovf_evt = strobe_d_reg && (mag > tps_pkg::SAMPLE_MAX);
		if (mag > tps_pkg::SAMPLE_MAX) begin
			mag = tps_pkg::SAMPLE_MAX;
		end
		sum_mag = 6'(mag);
		coef = tps_pkg::PCT_BASE + tps_pkg::SCALE_STEP_PCT *
			(int'(scale_reg) - int'(tps_pkg::SCALE_UNITY));
		prod = (mag * coef) / tps_pkg::PCT_BASE;
		if (prod > tps_pkg::LEVEL_MAX) begin
			prod = tps_pkg::LEVEL_MAX;
		end
		scaled_mag = 7'(prod);
		pos_next = (sum_v < 0) ? -{1'b0, scaled_mag} : {1'b0, scaled_mag};
		// single-ended mode leaves the negative leg idle
		neg_next = cfg_reg[tps_pkg::CFG_SINGLE_BIT] ? '0 : -pos_next;
	end
	a_unity_scale: assert property (scale_reg == tps_pkg::SCALE_UNITY |->
		scaled_mag == {1'b0, sum_mag})
		else $error("unity scale changed the amplitude");
	a_step_scale: assert property (scale_reg == tps_pkg::SCALE_UNITY + 6'h01
		|-> 32'(scaled_mag) == (32'(sum_mag) * 103) / 100)
		else $error("one scale step is not 3 percent");
	a_user_source: assert property (user_wave |-> src_cur == ram_rd[0 +: DW])
		else $error("user waveform not selected");

	// ---- over-current and interrupt status
	assign oc_evt = (tx_overcurrent ^ oc_state_reg) &&
		(edge_reg || tx_overcurrent);
	always_comb begin
		irq_stat_next = irq_stat_reg;
		// read clears, but an event in the same cycle wins
		if (rd_fire && s_axi_araddr == tps_pkg::ADDR_IRQ_STAT) begin
			irq_stat_next = '0;
		end
		if (ovf_evt) begin
			irq_stat_next[tps_pkg::OVF_BIT] = 1'b1;
		end
		if (oc_evt) begin
			irq_stat_next[tps_pkg::OC_BIT] = 1'b1;
		end
	end
	assign irq_out_n = ~|(irq_stat_reg & ~mask_reg);
	assign drive_on = global_oe && cfg_reg[tps_pkg::CFG_DRV_EN_BIT] &&
		!(oc_state_reg && cfg_reg[tps_pkg::CFG_TRI_OC_BIT]);
	assign line_out_pos_oe = drive_on;
	assign line_out_neg_oe = drive_on && !cfg_reg[tps_pkg::CFG_SINGLE_BIT];
	assign current_limit = oc_state_reg && !cfg_reg[tps_pkg::CFG_TRI_OC_BIT];

	a_ovf_flag: assert property (ovf_evt |=> irq_stat_reg[tps_pkg::OVF_BIT])
		else $error("overflow not captured");
	a_global_hiz: assert property (!global_oe |-> !line_out_pos_oe &&
		!line_out_neg_oe)
		else $error("drivers active with global enable low");
	a_oc_action: assert property (oc_state_reg |-> (current_limit ^
		cfg_reg[tps_pkg::CFG_TRI_OC_BIT]) &&
		!(cfg_reg[tps_pkg::CFG_TRI_OC_BIT] && line_out_pos_oe))
		else $error("over-current action wrong");
	a_oc_rise: assert property (tx_overcurrent && !oc_state_reg |=>
		oc_state_reg && irq_stat_reg[tps_pkg::OC_BIT])
		else $error("over-current edge not recorded");
	a_oc_irq: assert property (oc_evt && !mask_next[tps_pkg::OC_BIT] |=>
		!irq_out_n)
		else $error("unmasked over-current gave no interrupt");
	a_single_end: assert property (cfg_reg[tps_pkg::CFG_SINGLE_BIT] |->
		!line_out_neg_oe ##1 line_out_neg == '0)
		else $error("negative leg driven in single-ended mode");

	assign line_out_pos = pos_reg;
	assign line_out_neg = neg_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	tps_wave_ram #(
		.DATA_W(DW),
		.DEPTH(tps_pkg::NUM_SAMPLES),
		.ADDR_W(AW),
		.NUM_RD(3)
	) u_ram (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(ram_we),
		.wr_addr(acc_idx_reg),
		.wr_data(sample_reg),
		.rd_addr({acc_idx_reg, prev_ph_reg, cur_ph_reg}),
		.rd_data(ram_rd)
	);

	tps_ref_rom #(
		.NUM_RD(2)
	) u_rom (
		.aclk(aclk),
		.aresetn(aresetn),
		.set_sel(pulse_reg[2:0]),
		.rd_addr({prev_ph_reg, cur_ph_reg}),
		.rd_data(rom_rd)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= tps_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= tps_pkg::RESP_OKAY;
			rdata_reg <= '0;
			cfg_reg <= tps_pkg::CFG_RST;
			pulse_reg <= tps_pkg::PULSE_RST;
			scale_reg <= tps_pkg::SCALE_UNITY;
			mask_reg <= tps_pkg::MASK_RST;
			edge_reg <= 1'b0;
			acc_idx_reg <= '0;
			acc_rw_reg <= 1'b0;
			sample_reg <= '0;
			acc_state_reg <= tps_pkg::ACC_IDLE;
			cur_ph_reg <= '0;
			cur_act_reg <= 1'b0;
			cur_neg_reg <= 1'b0;
			prev_ph_reg <= '0;
			prev_act_reg <= 1'b0;
			prev_neg_reg <= 1'b0;
			cur_act_d_reg <= 1'b0;
			prev_act_d_reg <= 1'b0;
			cur_neg_d_reg <= 1'b0;
			prev_neg_d_reg <= 1'b0;
			strobe_d_reg <= 1'b0;
			pos_reg <= '0;
			neg_reg <= '0;
			oc_state_reg <= 1'b0;
			irq_stat_reg <= '0;
		end else begin
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			cfg_reg <= cfg_next;
			pulse_reg <= pulse_next;
			scale_reg <= scale_next;
			mask_reg <= mask_next;
			edge_reg <= edge_next;
			acc_idx_reg <= acc_idx_next;
			acc_rw_reg <= acc_rw_next;
			sample_reg <= sample_next;
			acc_state_reg <= acc_state_next;
			cur_ph_reg <= cur_ph_next;
			cur_act_reg <= cur_act_next;
			cur_neg_reg <= cur_neg_next;
			prev_ph_reg <= prev_ph_next;
			prev_act_reg <= prev_act_next;
			prev_neg_reg <= prev_neg_next;
			cur_act_d_reg <= cur_act_reg;
			prev_act_d_reg <= prev_act_reg;
			cur_neg_d_reg <= cur_neg_reg;
			prev_neg_d_reg <= prev_neg_reg;
			strobe_d_reg <= sample_strobe;
			pos_reg <= pos_next;
			neg_reg <= neg_next;
			oc_state_reg <= tx_overcurrent;
			irq_stat_reg <= irq_stat_next;
		end
	end
endmodule

// >>> bench/tps_line_model.sv
// Purpose: line side of the driver, sensing an overload on the pair
// Assumes: the bench asks for an overload through short_req
// Notes: sense lags one cycle, like a filtered current detector
`timescale 1ns/1ns
module tps_line_model (
	input wire logic aclk,
	input wire logic short_req,
	output logic tx_overcurrent
);
	// unknown only until the first edge, which falls inside reset
	always @(posedge aclk)
		tx_overcurrent <= short_req;
endmodule

// >>> bench/tps_top_tb.sv
// Purpose: self-checking bench of the transmit pulse shaper
// Assumes: one write and one read at most under way
// Notes: levels are checked as peaks over a bit, so latency is free
`timescale 1ns/1ns
module tps_top_tb;
	logic aclk = 1'h0, aresetn = 1'h0, global_oe = 1'h1, short_req = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
	logic rready = 1'h0, strobe = 1'h0, bstart = 1'h0, mark = 1'h0;
	logic [5:0] awaddr = 6'h00, araddr = 6'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, pos_oe, neg_oe;
	logic climit, irq_n, ocur;
	logic [7:0] pos, neg, peak, low;
	logic [6:0] s [20];
	int err_total = 0, checks_done = 0, mx;
	tps_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.global_oe(global_oe), .tx_overcurrent(ocur), .sample_strobe(strobe),
		.bit_start(bstart), .mark(mark), .mark_neg(1'h0), .line_out_pos(pos),
		.line_out_pos_oe(pos_oe), .line_out_neg(neg), .line_out_neg_oe(neg_oe),
		.current_limit(climit), .irq_out_n(irq_n));
	tps_line_model LINE (.aclk(aclk), .short_req(short_req),
		.tx_overcurrent(ocur));
	initial forever #5 aclk = ~aclk;
	task automatic give_verdict;
		if (err_total == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		// each channel is released on its own ready
		do begin
			@(posedge aclk);
			if (awready === 1'h1)
				awvalid <= 1'h0;
			if (wready === 1'h1)
				wvalid <= 1'h0;
		end while ((awvalid && awready !== 1'h1) ||
			(wvalid && wready !== 1'h1));
		do @(posedge aclk); while (bvalid !== 1'h1);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [5:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge aclk); while (rvalid !== 1'h1);
		d = rdata;
		rready <= 1'h0;
	endtask
	task automatic rc(input logic [5:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
	endtask
	// done must drop before the data is trusted
	task automatic acc(input int i, input logic rw, input logic [6:0] v);
		if (!rw)
			wr(tps_pkg::ADDR_SAMPLE, v);
		wr(tps_pkg::ADDR_ACC_CTRL, 32'h40 | rw << 5 | i);
		d = 32'h40;
		for (int n = 0; n < 4 && d[6] !== 1'h0; n++)
			rd(tps_pkg::ADDR_ACC_CTRL);
		chk(d[6], 32'h0);
		if (rw)
			rd(tps_pkg::ADDR_SAMPLE);
	endtask
	// two strobes a cycle apart would also do; spacing keeps margin
	task automatic send(input int nb);
		peak = 8'h00;
		low = 8'h00;
		// trailing cycles let the last strobed sample reach the registered level
		for (int i = 0; i < 32 * nb + 9; i++) begin
			@(posedge aclk);
			strobe <= i < 32 * nb && !i[0];
			bstart <= i < 32 * nb && i % 32 == 0;
			mark <= 1'h1;
			if ($signed(pos) > $signed(peak))
				peak = pos;
			if ($signed(neg) < $signed(low))
				low = neg;
		end
	endtask
	function automatic logic [7:0] lvl(input int m, input int sc);
		return 8'(m * (100 + 3 * (sc - 33)) / 100);
	endfunction
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		give_verdict;
	end
	initial begin
		void'($urandom(32'h3960));
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		rc(tps_pkg::ADDR_SCALE, 32'h21);
		rc(tps_pkg::ADDR_PULSE, 32'h1);
		rc(tps_pkg::ADDR_IRQ_MASK, 32'h90);
		rc(6'h3C, 32'h0);
		chk(rresp, tps_pkg::RESP_SLVERR);
		wr(6'h3C, 32'h0);
		chk(bresp, tps_pkg::RESP_SLVERR);
		wr(tps_pkg::ADDR_TX_CFG, 32'h42);
		chk(bresp, tps_pkg::RESP_OKAY);
		wt(1);
		chk({pos_oe, neg_oe}, 32'h3);
		global_oe <= 1'h0;
		wt(1);
		chk({pos_oe, neg_oe}, 32'h0);
		global_oe <= 1'h1;
		wr(tps_pkg::ADDR_TX_CFG, 32'h02);
		wt(1);
		chk({pos_oe, neg_oe}, 32'h0);
		wr(tps_pkg::ADDR_TX_CFG, 32'h42);
		for (int p = 0; p < 2; p++)
			for (int sc = 32; sc < 35; sc++) begin
				wr(tps_pkg::ADDR_PULSE, p);
				wr(tps_pkg::ADDR_SCALE, sc);
				send(1);
				chk(peak, lvl(p ? 60 : 48, sc));
				chk(low, 8'(-lvl(p ? 60 : 48, sc)));
			end
		mx = 0;
		for (int i = 0; i < 20; i++) begin
			s[i] = (i % 16 == 0) ? 7'h3F : 7'($urandom);
			if (!s[i][6] && s[i] > mx)
				mx = s[i];
			acc(i, 1'h0, s[i]);
		end
		for (int i = 0; i < 21; i++) begin
			acc(i, 1'h1, 7'h00);
			chk(d, i < 20 ? s[i] : 7'h00);
		end
		wr(tps_pkg::ADDR_PULSE, 32'h8 | ($urandom & 32'h7));
		wr(tps_pkg::ADDR_SCALE, 32'h21);
		wr(tps_pkg::ADDR_TX_CFG, 32'h4B);
		send(1);
		chk(peak, lvl(mx, 33));
		chk({low, neg_oe}, 32'h0);
		wr(tps_pkg::ADDR_IRQ_MASK, 32'h0);
		rd(tps_pkg::ADDR_IRQ_STAT);
		send(2);
		chk(irq_n, 32'h0);
		rc(tps_pkg::ADDR_IRQ_STAT, 32'h80);
		wt(1);
		chk(irq_n, 32'h1);
		wr(tps_pkg::ADDR_EDGE_SEL, 32'h10);
		short_req <= 1'h1;
		wt(4);
		chk({climit, irq_n}, 32'h2);
		rc(tps_pkg::ADDR_STATUS, 32'h10);
		rc(tps_pkg::ADDR_IRQ_STAT, 32'h10);
		wr(tps_pkg::ADDR_IRQ_MASK, 32'h10);
		wr(tps_pkg::ADDR_TX_CFG, 32'h5B);
		wt(1);
		chk({pos_oe, climit}, 32'h0);
		short_req <= 1'h0;
		wt(4);
		chk(irq_n, 32'h1);
		rc(tps_pkg::ADDR_IRQ_STAT, 32'h10);
		rc(tps_pkg::ADDR_STATUS, 32'h0);
		wr(tps_pkg::ADDR_EDGE_SEL, 32'h0);
		short_req <= 1'h1;
		wt(4);
		rc(tps_pkg::ADDR_IRQ_STAT, 32'h10);
		short_req <= 1'h0;
		wt(4);
		rc(tps_pkg::ADDR_IRQ_STAT, 32'h0);
		give_verdict;
	end
endmodule
